/* src/read_channel_pkg.sv */
// Shared constants for the read channel clock control and its controller.
// Assumes one 100 MHz clock; all slower rates are one-cycle ticks.
package read_channel_pkg;
	// Bank codes on the configuration link
	localparam logic [1:0]  BANK_00         = 2'h0;
	localparam logic [1:0]  BANK_01         = 2'h1;
	localparam logic [1:0]  BANK_10         = 2'h2;
	localparam logic [1:0]  BANK_11         = 2'h3;
	localparam int          BANK_W          = 16;
	// Bank (0,1) divider fields
	localparam int          IN_DIV_LSB      = 8;
	localparam int          IN_DIV_W        = 5;
	localparam int          FB_DIV_LSB      = 2;
	localparam int          FB_DIV_W        = 6;
	localparam logic [6:0]  DIV_OFFSET      = 7'h02;
	localparam logic [15:0] BANK01_RESET    = 16'h0104;
	localparam logic [15:0] BANK10_RESET    = 16'h0000;
	localparam logic [15:0] BANK11_RESET    = 16'h0000;
	// Bank (1,0) control bits
	localparam int          FREE_CLK_EN_BIT = 0;
	localparam int          SYNC_PD_BIT     = 2;
	localparam int          FREE_RUNNING_CLOCK_OUT_PD_BIT    = 3;
	localparam int          PUMP_RATIO_BIT  = 12;
	// Bank (1,1) strobe fields
	localparam int          STR_MAG_LSB     = 0;
	localparam int          STROBE_DIRECTION_BIT    = 3;
	localparam logic [2:0]  STR_MAG_INVALID = 3'h7;
	localparam logic [2:0]  STR_FIXED_STEPS = 3'h2;
	localparam int          STR_FIXED_PS    = 600;
	localparam logic [10:0] STR_STEP_PS     = 11'(STR_FIXED_PS);
	// Charge pump gains
	localparam logic [3:0]  GAIN_HIGH       = 4'h8;
	localparam logic [3:0]  GAIN_MID        = 4'h4;
	localparam logic [3:0]  GAIN_LOW        = 4'h2;
	// Oscillator phase accumulator width
	localparam int          ACC_W           = 7;
	// AHB-Lite register map of the controller
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_BANK01     = 8'h04;
	localparam logic [7:0]  ADDR_BANK10     = 8'h08;
	localparam logic [7:0]  ADDR_BANK11     = 8'h0C;
	localparam logic [7:0]  ADDR_STATUS     = 8'h10;
	localparam int          CTRL_RG_BIT     = 0;
	localparam int          ST_READ_BIT     = 0;
	localparam int          ST_FREE_RUNNING_CLOCK_OUT_BIT    = 1;
	localparam int          ST_BADSTR_BIT   = 2;
	localparam int          ST_REFUSED_BIT  = 3;
	localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
	localparam logic        HRESP_OKAY      = 1'b0;
	// Read mode sequencer states
	typedef enum logic [3:0] {
		MODE_NONREAD = 4'h1,
		MODE_ZPS     = 4'h2,
		MODE_READ    = 4'h4,
		MODE_EXIT    = 4'h8
	} read_mode_t;
endpackage

/* src/read_channel_if.sv */
// Link between the clock control device and its controlling party.
// Assumes both ends share clk; every signal is driven from a flip-flop.
`timescale 1ns/1ns
interface read_channel_if;
	logic        cfgWrite;
	logic [1:0]  cfgBank;
	logic [15:0] cfgData;
	logic        readGate;
	logic        inReadMode;
	logic        synthRunning;
	logic        strobeInvalid;

	modport device (
		input  cfgWrite,
		input  cfgBank,
		input  cfgData,
		input  readGate,
		output inReadMode,
		output synthRunning,
		output strobeInvalid
	);
	modport controller (
		output cfgWrite,
		output cfgBank,
		output cfgData,
		output readGate,
		input  inReadMode,
		input  synthRunning,
		input  strobeInvalid
	);
endinterface

/* src/read_channel_controller.sv */
// Controlling party: AHB-Lite slave that programs the clock control banks.
// Assumes a single AHB-Lite master and the device on the same clk.
`timescale 1ns/1ns
module read_channel_controller (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	read_channel_if.controller link
);
	import read_channel_pkg::*;

	typedef struct packed {
		logic        rdy;
		logic        readGate;
		logic [15:0] bank01;
		logic [15:0] bank10;
		logic [15:0] bank11;
		logic        refused;
		logic        aValid;
		logic        aWrite;
		logic [7:0]  aAddr;
		logic [31:0] rdata;
		logic        cfgWrite;
		logic [1:0]  cfgBank;
		logic [15:0] cfgData;
	} ctl_state_t;

	ctl_state_t state_reg;
	ctl_state_t state_next;
	logic [15:0] wr16;

	// Bus slave, register write checks and read mux
	always_comb begin
		state_next = state_reg;
		wr16 = hwdata[15:0];
		state_next.rdy = 1'b1;
		state_next.cfgWrite = 1'b0;
		if (state_reg.aValid && state_reg.aWrite) begin
			if (state_reg.aAddr == ADDR_CTRL) begin
				state_next.readGate = hwdata[CTRL_RG_BIT];
			end else if (state_reg.aAddr == ADDR_BANK01) begin
				if (wr16[IN_DIV_LSB +: IN_DIV_W] == '0 ||
				    wr16[FB_DIV_LSB +: FB_DIV_W] == '0) begin
					state_next.refused = 1'b1;
				end else begin
					state_next.bank01 = wr16;
					state_next.cfgWrite = 1'b1;
					state_next.cfgBank = BANK_01;
					state_next.cfgData = wr16;
				end
			end else if (state_reg.aAddr == ADDR_BANK10) begin
				// Synchronizer follows synthesizer into power-down
				if (wr16[FREE_RUNNING_CLOCK_OUT_PD_BIT]) begin
					wr16[SYNC_PD_BIT] = 1'b1;
				end
				state_next.bank10 = wr16;
				state_next.cfgWrite = 1'b1;
				state_next.cfgBank = BANK_10;
				state_next.cfgData = wr16;
			end else if (state_reg.aAddr == ADDR_BANK11) begin
				if (wr16[STR_MAG_LSB +: 3] == STR_MAG_INVALID) begin
					state_next.refused = 1'b1;
				end else begin
					state_next.bank11 = wr16;
					state_next.cfgWrite = 1'b1;
					state_next.cfgBank = BANK_11;
					state_next.cfgData = wr16;
				end
			end else if (state_reg.aAddr == ADDR_STATUS) begin
				// Write one clears; a refusal this cycle wins
				if (hwdata[ST_REFUSED_BIT]) begin
					state_next.refused = 1'b0;
				end
			end
		end
		state_next.aValid = 1'b0;
		if (hsel && hready && htrans == HTRANS_NONSEQ) begin
			state_next.aValid = 1'b1;
			state_next.aWrite = hwrite;
			state_next.aAddr = haddr[7:0];
			if (!hwrite) begin
				state_next.rdata = '0;
				if (haddr[7:0] == ADDR_CTRL) begin
					state_next.rdata[CTRL_RG_BIT] = state_next.readGate;
				end else if (haddr[7:0] == ADDR_BANK01) begin
					state_next.rdata[15:0] = state_next.bank01;
				end else if (haddr[7:0] == ADDR_BANK10) begin
					state_next.rdata[15:0] = state_next.bank10;
				end else if (haddr[7:0] == ADDR_BANK11) begin
					state_next.rdata[15:0] = state_next.bank11;
				end else if (haddr[7:0] == ADDR_STATUS) begin
					state_next.rdata[ST_READ_BIT] = link.inReadMode;
					state_next.rdata[ST_FREE_RUNNING_CLOCK_OUT_BIT] = link.synthRunning;
					state_next.rdata[ST_BADSTR_BIT] = link.strobeInvalid;
					state_next.rdata[ST_REFUSED_BIT] = state_next.refused;
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= '{rdy: 1'b0, readGate: 1'b0,
				bank01: BANK01_RESET, bank10: BANK10_RESET,
				bank11: BANK11_RESET, refused: 1'b0, aValid: 1'b0,
				aWrite: 1'b0, aAddr: 8'h00, rdata: 32'h00000000,
				cfgWrite: 1'b0, cfgBank: BANK_00, cfgData: 16'h0000};
		end else begin
			state_reg <= state_next;
		end
	end

	assign hreadyout = state_reg.rdy;
	assign hresp = HRESP_OKAY & state_reg.rdy;
	assign hrdata = state_reg.rdata;
	assign link.cfgWrite = state_reg.cfgWrite;
	assign link.cfgBank = state_reg.cfgBank;
	assign link.cfgData = state_reg.cfgData;
	assign link.readGate = state_reg.readGate;
endmodule

/* src/read_channel_clock_control.sv */
// Clock control of the read channel: synthesizer, read clock mux, strobe.
// Assumes clk is the reference; oscillators are modelled as tick streams.
`timescale 1ns/1ns
module read_channel_clock_control (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        encodedData,
	input  wire logic        pumpGainPin,
	output logic             syncClock,
	output logic             freeRunningClockOut,
	output logic             resyncedDataOut,
	output logic [3:0]       pumpCurrentGain,
	output logic             strobeDirection,
	output logic [2:0]       strobeMagnitude,
	output logic [10:0]      strobeFixedPs,
	output logic [2:0]       strobeSixteenths,
	read_channel_if.device   link
);
	import read_channel_pkg::*;

	typedef struct packed {
		read_mode_t       mode;
		logic [15:0]      bank01;
		logic [15:0]      bank10;
		logic [15:0]      bank11;
		logic [15:0]      pend01;
		logic [15:0]      pend11;
		logic             pend01Valid;
		logic             pend11Valid;
		logic [ACC_W-1:0] synthAcc;
		logic [ACC_W-1:0] recAcc;
		logic             sel;
		logic             sclk;
		logic             freeClk;
		logic             dataSeen;
		logic             dataOut;
		logic [3:0]       gain;
		logic             strDir;
		logic [2:0]       strMag;
		logic [10:0]      strPs;
		logic [2:0]       strSix;
		logic             strBad;
		logic             inRead;
		logic             synthOn;
	} dev_state_t;

	dev_state_t state_reg;
	dev_state_t state_next;
	logic [ACC_W-1:0] inMod;
	logic [ACC_W-1:0] fbMod;
	logic [ACC_W-1:0] sum;
	logic             synthRun;
	logic             recRun;
	logic             synthTick;
	logic             recTick;
	logic             curTick;
	logic             wantSel;
	logic [2:0]       mag;

	always_comb begin
		state_next = state_reg;
		// Divider moduli from the applied bank (0,1) word
		inMod = ACC_W'(state_reg.bank01[IN_DIV_LSB +: IN_DIV_W])
			+ DIV_OFFSET;
		fbMod = ACC_W'(state_reg.bank01[FB_DIV_LSB +: FB_DIV_W])
			+ DIV_OFFSET;
		synthRun = !state_reg.bank10[FREE_RUNNING_CLOCK_OUT_PD_BIT]
			&& state_reg.bank01[IN_DIV_LSB +: IN_DIV_W] != '0
			&& state_reg.bank01[FB_DIV_LSB +: FB_DIV_W] != '0;
		recRun = synthRun && !state_reg.bank10[SYNC_PD_BIT];
		// Synthesizer: rate = clk * fbMod / inMod, one tick per clk at most
		synthTick = 1'b0;
		sum = state_reg.synthAcc + fbMod;
		if (synthRun) begin
			if (sum >= inMod) begin
				state_next.synthAcc = (sum - inMod >= inMod) ? '0
					: sum - inMod;
				synthTick = 1'b1;
			end else begin
				state_next.synthAcc = sum;
			end
		end
		// Recovery oscillator runs at the same rate, own phase
		recTick = 1'b0;
		sum = state_reg.recAcc + fbMod;
		if (recRun && state_reg.mode != MODE_ZPS) begin
			if (sum >= inMod) begin
				state_next.recAcc = (sum - inMod >= inMod) ? '0
					: sum - inMod;
				recTick = 1'b1;
			end else begin
				state_next.recAcc = sum;
			end
		end
		// Read mode sequencer with phase restart
		wantSel = 1'b0;
		case (state_reg.mode)
			MODE_NONREAD: begin
				if (link.readGate && recRun) begin
					state_next.mode = MODE_ZPS;
				end
			end
			MODE_ZPS: begin
				if (!link.readGate || !recRun) begin
					state_next.mode = MODE_NONREAD;
				end else if (encodedData) begin
					state_next.recAcc = '0;
					recTick = 1'b1;
					state_next.mode = MODE_READ;
				end
			end
			MODE_READ: begin
				wantSel = 1'b1;
				if (!link.readGate || !recRun) begin
					state_next.mode = MODE_EXIT;
				end
			end
			MODE_EXIT: begin
				// Relock only once the mux is back on the free_running_clock_out
				if (!state_reg.sel) begin
					state_next.recAcc = state_next.synthAcc;
					state_next.mode = MODE_NONREAD;
				end
			end
			default: begin
				state_next.mode = MODE_NONREAD;
			end
		endcase
		// Glitch-free mux: swap only in a low phase, at a tick
		curTick = state_reg.sel ? recTick : synthTick;
		if (state_reg.sel && !recRun) begin
			curTick = synthTick;
		end
		if (curTick) begin
			if (!state_reg.sclk && state_reg.sel != wantSel) begin
				state_next.sel = wantSel;
			end else begin
				state_next.sclk = !state_reg.sclk;
			end
		end
		// Free-running output held high until enabled
		if (!state_reg.bank10[FREE_CLK_EN_BIT]) begin
			state_next.freeClk = 1'b1;
		end else if (synthTick) begin
			state_next.freeClk = !state_reg.freeClk;
		end
		// Resynchronized data on recovery ticks in read mode
		if (encodedData) begin
			state_next.dataSeen = 1'b1;
		end
		if (state_reg.mode == MODE_READ && recTick) begin
			state_next.dataOut = state_reg.dataSeen && !state_reg.strBad;
			state_next.dataSeen = encodedData;
		end
		// Pending banks apply at terminal count or when stopped
		if (synthTick || !synthRun) begin
			if (state_reg.pend01Valid) begin
				state_next.bank01 = state_reg.pend01;
				state_next.pend01Valid = 1'b0;
			end
			if (state_reg.pend11Valid) begin
				state_next.bank11 = state_reg.pend11;
				state_next.pend11Valid = 1'b0;
			end
		end
		// New writes win over a same-cycle apply
		if (link.cfgWrite) begin
			if (link.cfgBank == BANK_01) begin
				state_next.pend01 = link.cfgData;
				state_next.pend01Valid = 1'b1;
			end else if (link.cfgBank == BANK_10) begin
				state_next.bank10 = link.cfgData;
			end else if (link.cfgBank == BANK_11) begin
				state_next.pend11 = link.cfgData;
				state_next.pend11Valid = 1'b1;
			end
		end
		// Charge pump gain decode
		case ({pumpGainPin, state_reg.bank10[PUMP_RATIO_BIT]})
			2'b01: state_next.gain = GAIN_MID;
			2'b11: state_next.gain = GAIN_LOW;
			default: state_next.gain = GAIN_HIGH;
		endcase
		// Strobe decode from the bank, registered straight onto the outputs
		mag = state_reg.bank11[STR_MAG_LSB +: 3];
		state_next.strMag = mag;
		state_next.strDir = state_reg.bank11[STROBE_DIRECTION_BIT] && mag != '0;
		state_next.strBad = mag == STR_MAG_INVALID;
		if (mag > STR_FIXED_STEPS) begin
			state_next.strPs = STR_STEP_PS * 11'(STR_FIXED_STEPS);
			state_next.strSix = mag - STR_FIXED_STEPS;
		end else begin
			state_next.strPs = STR_STEP_PS * 11'(mag);
			state_next.strSix = 3'h0;
		end
		state_next.inRead = state_next.mode == MODE_READ;
		state_next.synthOn = synthRun;
	end

	// State register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= '{mode: MODE_NONREAD, bank01: BANK01_RESET,
				bank10: BANK10_RESET, bank11: BANK11_RESET,
				pend01: BANK01_RESET, pend11: BANK11_RESET,
				pend01Valid: 1'b0, pend11Valid: 1'b0,
				synthAcc: '0, recAcc: '0, sel: 1'b0, sclk: 1'b0,
				freeClk: 1'b1, dataSeen: 1'b0, dataOut: 1'b0,
				gain: GAIN_HIGH, strDir: 1'b0, strMag: 3'h0,
				strPs: 11'h000, strSix: 3'h0, strBad: 1'b0,
				inRead: 1'b0, synthOn: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign syncClock = state_reg.sclk;
	assign freeRunningClockOut = state_reg.freeClk;
	assign resyncedDataOut = state_reg.dataOut;
	assign pumpCurrentGain = state_reg.gain;
	assign strobeDirection = state_reg.strDir;
	assign strobeMagnitude = state_reg.strMag;
	assign strobeFixedPs = state_reg.strPs;
	assign strobeSixteenths = state_reg.strSix;
	assign link.inReadMode = state_reg.inRead;
	assign link.synthRunning = state_reg.synthOn;
	assign link.strobeInvalid = state_reg.strBad;
endmodule

/* verification/read_channel_props.sv */
// Concurrent checks on the link between controller and clock control.
// Assumes one clk for both ends; reset async active high.
`timescale 1ns/1ns
module read_channel_props
	import read_channel_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        cfgWrite,
	input wire logic [1:0]  cfgBank,
	input wire logic [15:0] cfgData,
	input wire logic        readGate,
	input wire logic        inReadMode,
	input wire logic        synthRunning,
	input wire logic        strobeInvalid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Bank (1,0) writes with power-down set or clear
	sequence sPdOn;
		cfgWrite && cfgBank == BANK_10 && cfgData[FREE_RUNNING_CLOCK_OUT_PD_BIT];
	endsequence
	sequence sPdOff;
		cfgWrite && cfgBank == BANK_10 && !cfgData[FREE_RUNNING_CLOCK_OUT_PD_BIT];
	endsequence

	AST_PRESET_RUNS: assert property ($past(reset) |=> synthRunning)
		else $error("free_running_clock_out idle after reset");
	AST_PD_STOPS: assert property (sPdOn |-> ##[1:3] !synthRunning)
		else $error("free_running_clock_out still running after power-down");
	AST_PD_RESUMES: assert property (sPdOff |-> ##[1:4] synthRunning)
		else $error("free_running_clock_out not back after power-up");
	AST_SYNC_PD_FOLLOWS: assert property (sPdOn |-> cfgData[SYNC_PD_BIT])
		else $error("recovery left powered with free_running_clock_out down");
	AST_NO_ZERO_DIV: assert property (cfgWrite && cfgBank == BANK_01
		|-> cfgData[IN_DIV_LSB +: IN_DIV_W] != '0
		&& cfgData[FB_DIV_LSB +: FB_DIV_W] != '0)
		else $error("zero divider word sent");
	AST_NO_BAD_STROBE: assert property (cfgWrite && cfgBank == BANK_11
		|-> cfgData[STR_MAG_LSB +: 3] != STR_MAG_INVALID)
		else $error("invalid strobe code sent");
	AST_STROBE_OK: assert property (!strobeInvalid)
		else $error("strobe flagged invalid");
	AST_READ_NEEDS_GATE: assert property ($rose(inReadMode) |-> $past(readGate))
		else $error("read mode without gate");
	AST_IDLE_STAYS: assert property (!readGate && !inReadMode |=> !inReadMode)
		else $error("read mode entered with gate low");
	AST_EXIT_BOUNDED: assert property ($fell(readGate) |-> ##[1:64] !inReadMode)
		else $error("read mode not left");
endmodule

/* verification/read_channel_clock_control_tb.sv */
// Bench: controller and clock control joined by their link.
// Assumes AHB-Lite single master; inputs change by NBA after posedge.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin \
	badCount++; $display("unexpected %s exp=%0h got=%0h", nm, ex, got); \
	end end
module read_channel_clock_control_tb;
	import read_channel_pkg::*;
	logic        clk;
	logic        reset;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        encodedData;
	logic        pumpGainPin;
	logic        syncClock;
	logic        freeRunningClockOut;
	logic        resyncedDataOut;
	logic [3:0]  pumpCurrentGain;
	logic        strobeDirection;
	logic [2:0]  strobeMagnitude;
	logic [10:0] strobeFixedPs;
	logic [2:0]  strobeSixteenths;
	logic [31:0] rdVal;
	logic [2:0]  m;
	logic        sg;
	logic        armed;
	logic        lastSync;
	logic [3:0]  gainExp [4];
	int          badCount;
	int          nTests;
	int          cycles;
	int          phaseLen;
	int          nFree;
	int          nSync;
	int          nData;

	read_channel_if link ();
	read_channel_controller u_read_channel_controller (.clk, .reset,
		.hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.link(link.controller));
	read_channel_clock_control u_read_channel_clock_control (.clk,
		.reset, .encodedData, .pumpGainPin, .syncClock,
		.freeRunningClockOut, .resyncedDataOut, .pumpCurrentGain,
		.strobeDirection, .strobeMagnitude, .strobeFixedPs,
		.strobeSixteenths, .link(link.device));
	read_channel_props u_read_channel_props (.clk, .reset,
		.cfgWrite(link.cfgWrite), .cfgBank(link.cfgBank),
		.cfgData(link.cfgData), .readGate(link.readGate),
		.inReadMode(link.inReadMode), .synthRunning(link.synthRunning),
		.strobeInvalid(link.strobeInvalid));

	// Clock source
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic endSim();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			badCount++;
			endSim();
		end
	end

	// Phase length watch on the sync clock output
	always @(posedge clk) begin
		if (syncClock !== lastSync) begin
			if (armed) `CHK("sync phase", 1'b1, phaseLen >= 2)
			phaseLen = 1;
		end else begin
			phaseLen++;
		end
		lastSync = syncClock;
	end

	// One single AHB-Lite transfer, address then data phase
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdVal = hrdata;
	endtask

	// Read a register and compare
	task automatic rdChk(input logic [7:0] a, input logic [31:0] ex);
		ahb(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), ex, rdVal)
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Count level changes of both clock outputs over n cycles
	task automatic countEdges(input int n);
		logic f;
		logic s;
		nFree = 0;
		nSync = 0;
		f = freeRunningClockOut;
		s = syncClock;
		repeat (n) begin
			@(posedge clk);
			if (freeRunningClockOut !== f) nFree++;
			if (syncClock !== s) nSync++;
			f = freeRunningClockOut;
			s = syncClock;
		end
	endtask

	// Main sequence
	initial begin
		reset = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		encodedData = 1'b0;
		pumpGainPin = 1'b0;
		armed = 1'b0;
		lastSync = 1'b0;
		gainExp = '{GAIN_HIGH, GAIN_MID, GAIN_HIGH, GAIN_LOW};
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		rdChk(ADDR_STATUS, 32'h2);
		rdChk(ADDR_BANK01, 32'h104);
		rdChk(8'h20, 32'h0);
		countEdges(20);
		`CHK("free idle", 1'b1, freeRunningClockOut)
		`CHK("free edges", 0, nFree)
		// Gain table over pin and ratio bit
		for (int i = 0; i < 4; i++) begin
			pumpGainPin <= i[1];
			ahb(1'b1, ADDR_BANK10, {19'h0, i[0], 12'h0});
			tick(3);
			`CHK("gain", gainExp[i], pumpCurrentGain)
		end
		// Ratio 3/11 on both clock outputs
		ahb(1'b1, ADDR_BANK10, 32'h1);
		ahb(1'b1, ADDR_BANK01, 32'h904);
		rdChk(ADDR_BANK01, 32'h904);
		tick(4);
		countEdges(110);
		`CHK("free rate", 1'b1, nFree >= 29 && nFree <= 31)
		`CHK("sync rate", 1'b1, nSync >= 29 && nSync <= 31)
		// Zero divider words are refused
		ahb(1'b1, ADDR_BANK01, 32'h4);
		rdChk(ADDR_STATUS, 32'hA);
		ahb(1'b1, ADDR_STATUS, 32'h8);
		ahb(1'b1, ADDR_BANK01, 32'h900);
		rdChk(ADDR_BANK01, 32'h904);
		ahb(1'b1, ADDR_STATUS, 32'h8);
		// All thirteen window positions, both signs
		for (int i = 0; i < 14; i++) begin
			m = 3'(i % 7);
			sg = (i >= 7);
			ahb(1'b1, ADDR_BANK11, {28'h0, sg, m});
			tick(8);
			`CHK("mag", m, strobeMagnitude)
			`CHK("dir", sg && m != 0, strobeDirection)
			`CHK("fixed", 11'(STR_STEP_PS * (m > 2 ? 2 : m)), strobeFixedPs)
			`CHK("16th", m > 2 ? m - 3'h2 : 3'h0, strobeSixteenths)
		end
		ahb(1'b1, ADDR_BANK11, 32'h7);
		rdChk(ADDR_BANK11, 32'hE);
		rdChk(ADDR_STATUS, 32'hA);
		ahb(1'b1, ADDR_STATUS, 32'h8);
		// Free_running_clock_out power-down keeps settings
		ahb(1'b1, ADDR_BANK10, 32'h9);
		rdChk(ADDR_BANK10, 32'hD);
		rdChk(ADDR_STATUS, 32'h0);
		rdChk(ADDR_BANK01, 32'h904);
		ahb(1'b1, ADDR_BANK10, 32'h1);
		tick(4);
		rdChk(ADDR_STATUS, 32'h2);
		// Read entry and exit at ratio 1/2
		ahb(1'b1, ADDR_BANK01, 32'h404);
		tick(10);
		armed = 1'b1;
		ahb(1'b1, ADDR_CTRL, 32'h1);
		tick(4);
		rdChk(ADDR_STATUS, 32'h2);
		encodedData <= 1'b1;
		@(posedge clk);
		encodedData <= 1'b0;
		nData = 0;
		repeat (4) begin
			@(posedge clk);
			if (resyncedDataOut === 1'b1) nData++;
		end
		`CHK("data out", 1'b1, nData > 0)
		rdChk(ADDR_STATUS, 32'h3);
		countEdges(20);
		`CHK("read rate", 1'b1, nSync >= 9 && nSync <= 11)
		`CHK("data idle", 1'b0, resyncedDataOut)
		ahb(1'b1, ADDR_CTRL, 32'h0);
		tick(8);
		rdChk(ADDR_STATUS, 32'h2);
		countEdges(20);
		`CHK("exit rate", 1'b1, nSync >= 9 && nSync <= 11)
		armed = 1'b0;
		endSim();
	end
endmodule
